/* irq_ctrl_pkg.sv */
// constants and carrier types for the interrupt request control block
// Notes on behaviour
// - a pending enabled request suspends the main program so its source can be serviced.
// - requests come from the external pins, the pin-change input and the internal sources.
// - hardware sets each request flag on its condition; enables change only by software writes.
// - every source has one enable bit and one request flag of its own.
// - registers are primary control, grouped control and one edge-select register.
// - all registers are reached by plain data reads and writes.
// - primary register a holds comparator-a/ext-b/ext-a flags, their enables and global enable; bit 7 unused.
// - primary register c holds group-d, timebase-b, timebase-a, group-c flags, then their enables.
// - edge field of ext pin a: 00 off, 01 rising, 10 falling, 11 both.
// - bits 3 to 2 of the edge-select register pick the edge of ext pin b with the same code.
// - edge-select bits 7 to 4 read zero and the edge fields reset to zero.
package irq_ctrl_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int REG_COUNT = 8;
    // register indices in the data memory window
    localparam logic [2:0] IDX_EDGE = 3'h0;
    localparam logic [2:0] IDX_PRI_A = 3'h1;
    localparam logic [2:0] IDX_PRI_B = 3'h2;
    localparam logic [2:0] IDX_PRI_C = 3'h3;
    localparam logic [2:0] IDX_GRP_A = 3'h4;
    localparam logic [2:0] IDX_GRP_B = 3'h5;
    localparam logic [2:0] IDX_GRP_C = 3'h6;
    localparam logic [2:0] IDX_GRP_D = 3'h7;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // implemented bits per register
    localparam logic [7:0] MASK_EDGE = 8'h0f;
    localparam logic [7:0] MASK_PRI_A = 8'h7f;
    localparam logic [7:0] MASK_PRI_B = 8'h77;
    localparam logic [7:0] MASK_PRI_C = 8'hff;
    localparam logic [7:0] MASK_GRP_A = 8'hff;
    localparam logic [7:0] MASK_GRP_B = 8'h77;
    localparam logic [7:0] MASK_GRP_C = 8'hff;
    localparam logic [7:0] MASK_GRP_D = 8'h33;
    // field positions
    localparam int BIT_GLOBAL_EN = 0;
    localparam int BIT_EXT_A_F = 4;
    localparam int BIT_EXT_B_F = 5;
    localparam int BIT_CMP_A_F = 6;
    localparam int BIT_CMP_B_F = 4;
    localparam int BIT_GRP_A_F = 5;
    localparam int BIT_GRP_B_F = 6;
    localparam int BIT_GRP_C_F = 4;
    localparam int BIT_TB_A_F = 5;
    localparam int BIT_TB_B_F = 6;
    localparam int BIT_GRP_D_F = 7;
    localparam int EDGE_A_LSB = 0;
    localparam int EDGE_B_LSB = 2;
    // edge field codes
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // internal request pulses, one clock each
    typedef struct packed {
        logic cmp_a;
        logic cmp_b;
        logic tb_a;
        logic tb_b;
        logic tm0_p;
        logic tm0_a;
        logic tm1_p;
        logic tm1_a;
        logic tm1_b;
        logic tm2_p;
        logic tm2_a;
        logic tm3_p;
        logic tm3_a;
        logic eeprom;
        logic low_voltage_detector;
        logic sim;
    } irq_src_s;

    // data memory access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sfr_req_s;
endpackage

/* pin_edge_sense.sv */
// synchroniser and edge qualifier for external request pins
`timescale 1ns/100ps
`default_nettype none
module pin_edge_sense
    import irq_ctrl_pkg::*;
#(
    parameter int N = 3
) (
    input wire logic i_ref_clk, // system clock
    input wire logic i_srst, // sync reset, high
    input wire logic [N-1:0] i_pins, // raw pins
    input wire logic [N-1:0][1:0] i_modes, // edge code per pin
    output logic [N-1:0] o_hit // one-cycle edge pulse
);
    // refused at elaboration, the pin vector would be empty
    if (N < 1) begin : g_bad_pins
        $error("pin_edge_sense needs at least one pin");
    end

    typedef struct packed {
        logic [N-1:0] meta;
        logic [N-1:0] sync;
        logic [N-1:0] prev;
        logic [N-1:0] hit;
    } edge_state_s;

    edge_state_s s_q, s_d;

    // meta is read only by sync; edges are judged on sync against prev
    always_comb begin
        s_d = s_q;
        s_d.meta = i_pins;
        s_d.sync = s_q.meta;
        s_d.prev = s_q.sync;
        for (int k = 0; k < N; k++) begin
            case (i_modes[k])
                EDGE_RISE: s_d.hit[k] = s_q.sync[k] & ~s_q.prev[k];
                EDGE_FALL: s_d.hit[k] = ~s_q.sync[k] & s_q.prev[k];
                EDGE_BOTH: s_d.hit[k] = s_q.sync[k] ^ s_q.prev[k];
                default: s_d.hit[k] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_hit = s_q.hit;

    // a hit never appears in pin slot 0 while that slot is disabled
    edge_off_quiet_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        ($past(i_modes[0]) == EDGE_OFF) |-> !o_hit[0])
        else $error("edge hit while pin edge disabled");
    rise_only_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_hit[0] && $past(i_modes[0]) == EDGE_RISE) |-> $past(s_q.sync[0], 2) == 1'b0)
        else $error("rising hit without a low level before");
endmodule
`default_nettype wire

/* irq_request_ctrl.sv */
// interrupt request flags, enables, grouping and suspend request
`timescale 1ns/100ps
`default_nettype none
module irq_request_ctrl
    import irq_ctrl_pkg::*;
#(
    parameter int EXT_PINS = 2
) (
    input wire logic i_ref_clk, // system clock, 100 MHz
    input wire logic i_srst, // sync reset, high
    input wire sfr_req_s i_sfr, // data memory access
    output logic [DATA_W-1:0] o_sfr_rdata, // read data, registered
    output logic o_sfr_rvalid, // read data valid pulse
    input wire logic [EXT_PINS-1:0] i_external_request_pins, // async pins
    input wire logic i_pin_change_request_input, // async, rising edge requests
    input wire irq_src_s i_src, // internal request pulses
    output logic o_irq_suspend // suspend main program, level
);
    // refused at elaboration, the edge-select register only has two fields
    if (EXT_PINS != 2) begin : g_bad_ext_pins
        $error("only two external pins have edge fields");
    end

    typedef logic [REG_COUNT-1:0][DATA_W-1:0] reg_file_t;

    typedef struct packed {
        reg_file_t regs;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic suspend;
    } ctrl_state_s;

    ctrl_state_s s_q, s_d;
    logic [EXT_PINS:0] pin_hit;
    logic [EXT_PINS:0][1:0] pin_mode;
    reg_file_t set_v;
    logic grp_a_any, grp_b_any, grp_c_any, grp_d_any;
    logic pri_a_any, pri_b_any, pri_c_any;

    // implemented bits; unimplemented ones store and read as zero
    function automatic logic [7:0] reg_mask(input logic [2:0] idx);
        case (idx)
            IDX_EDGE: reg_mask = MASK_EDGE;
            IDX_PRI_A: reg_mask = MASK_PRI_A;
            IDX_PRI_B: reg_mask = MASK_PRI_B;
            IDX_PRI_C: reg_mask = MASK_PRI_C;
            IDX_GRP_A: reg_mask = MASK_GRP_A;
            IDX_GRP_B: reg_mask = MASK_GRP_B;
            IDX_GRP_C: reg_mask = MASK_GRP_C;
            default: reg_mask = MASK_GRP_D;
        endcase
    endfunction

    // any flag whose paired enable is also set
    function automatic logic pair_hit(input logic [3:0] flags, input logic [3:0] ens);
        pair_hit = |(flags & ens);
    endfunction

    // ext pins a, b and the pin-change input share one synchroniser
    assign pin_mode[0] = s_q.regs[IDX_EDGE][EDGE_A_LSB +: 2];
    assign pin_mode[1] = s_q.regs[IDX_EDGE][EDGE_B_LSB +: 2];
    assign pin_mode[2] = EDGE_RISE;

    pin_edge_sense #(
        .N(EXT_PINS + 1)
    ) u_pins (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_pins({i_pin_change_request_input, i_external_request_pins}),
        .i_modes(pin_mode),
        .o_hit(pin_hit)
    );

    // grouped flags follow the enabled members of each grouped register
    assign grp_a_any = pair_hit(s_q.regs[IDX_GRP_A][7:4], s_q.regs[IDX_GRP_A][3:0]);
    assign grp_b_any = pair_hit(s_q.regs[IDX_GRP_B][7:4], s_q.regs[IDX_GRP_B][3:0]);
    assign grp_c_any = pair_hit(s_q.regs[IDX_GRP_C][7:4], s_q.regs[IDX_GRP_C][3:0]);
    assign grp_d_any = pair_hit(s_q.regs[IDX_GRP_D][7:4], s_q.regs[IDX_GRP_D][3:0]);

    // primary a pairs flags 6:4 with enables 3:1, the others pair nibbles
    assign pri_a_any = pair_hit({1'b0, s_q.regs[IDX_PRI_A][6:4]}, {1'b0, s_q.regs[IDX_PRI_A][3:1]});
    assign pri_b_any = pair_hit(s_q.regs[IDX_PRI_B][7:4], s_q.regs[IDX_PRI_B][3:0]);
    assign pri_c_any = pair_hit(s_q.regs[IDX_PRI_C][7:4], s_q.regs[IDX_PRI_C][3:0]);

    // hardware set vector, one bit per request flag
    always_comb begin
        set_v = '0;
        set_v[IDX_PRI_A][BIT_EXT_A_F] = pin_hit[0];
        set_v[IDX_PRI_A][BIT_EXT_B_F] = pin_hit[1];
        set_v[IDX_PRI_A][BIT_CMP_A_F] = i_src.cmp_a;
        set_v[IDX_PRI_B][BIT_CMP_B_F] = i_src.cmp_b;
        set_v[IDX_PRI_B][BIT_GRP_A_F] = grp_a_any;
        set_v[IDX_PRI_B][BIT_GRP_B_F] = grp_b_any;
        set_v[IDX_PRI_C][BIT_GRP_C_F] = grp_c_any;
        set_v[IDX_PRI_C][BIT_TB_A_F] = i_src.tb_a;
        set_v[IDX_PRI_C][BIT_TB_B_F] = i_src.tb_b;
        set_v[IDX_PRI_C][BIT_GRP_D_F] = grp_d_any;
        set_v[IDX_GRP_A][7:4] = {i_src.tm2_a, i_src.tm2_p, i_src.tm0_a, i_src.tm0_p};
        set_v[IDX_GRP_B][7:4] = {1'b0, i_src.tm1_b, i_src.tm1_a, i_src.tm1_p};
        set_v[IDX_GRP_C][7:4] = {i_src.eeprom, i_src.low_voltage_detector, pin_hit[2], i_src.sim};
        set_v[IDX_GRP_D][7:4] = {2'b00, i_src.tm3_a, i_src.tm3_p};
    end

    // next state: write first, then hardware sets on top so a set wins a clear
    always_comb begin
        s_d = s_q;
        if (i_sfr.wr) begin
            s_d.regs[i_sfr.addr] = i_sfr.wdata & reg_mask(i_sfr.addr);
        end
        for (int r = 0; r < REG_COUNT; r++) begin
            s_d.regs[r] = s_d.regs[r] | (set_v[r] & reg_mask(3'(r)));
        end
        s_d.rvalid = i_sfr.rd;
        s_d.rdata = i_sfr.rd ? s_q.regs[i_sfr.addr] : s_q.rdata;
        // global enable gates all three primary groups
        s_d.suspend = s_q.regs[IDX_PRI_A][BIT_GLOBAL_EN]
            & (pri_a_any | pri_b_any | pri_c_any);
    end

    // every register, including the edge fields, clears on reset
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            s_q.regs <= {REG_COUNT{RESET_VALUE}};
            s_q.rdata <= RESET_VALUE;
            s_q.rvalid <= 1'b0;
            s_q.suspend <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sfr_rdata = s_q.rdata;
    assign o_sfr_rvalid = s_q.rvalid;
    assign o_irq_suspend = s_q.suspend;

    // checks of the request path, all on the system clock
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);

    logic glob_en;
    assign glob_en = s_q.regs[IDX_PRI_A][BIT_GLOBAL_EN];

    suspend_cause_a: assert property ($rose(o_irq_suspend) |-> $past(glob_en))
        else $error("suspend raised without global enable");
    global_gate_a: assert property ((!glob_en ##1 !glob_en) |-> !o_irq_suspend)
        else $error("suspend while global enable low");
    enabled_hit_a: assert property ((glob_en && pri_c_any && !(i_sfr.wr && i_sfr.addr == IDX_PRI_A))
        |=> o_irq_suspend)
        else $error("enabled pending request did not suspend");
    cmp_set_wins_a: assert property (i_src.cmp_a |=> s_q.regs[IDX_PRI_A][BIT_CMP_A_F])
        else $error("comparator flag lost");
    ext_flag_set_a: assert property (pin_hit[0] |=> s_q.regs[IDX_PRI_A][BIT_EXT_A_F])
        else $error("ext pin a flag not set on edge");
    enable_sw_only_a: assert property (!$past(i_sfr.wr)
        |-> s_q.regs[IDX_PRI_C][3:0] == $past(s_q.regs[IDX_PRI_C][3:0]))
        else $error("enable bits changed without write");
    tb_flag_a: assert property (i_src.tb_b |=> s_q.regs[IDX_PRI_C][BIT_TB_B_F])
        else $error("timebase b flag not set");
    group_flag_a: assert property (grp_a_any |=> s_q.regs[IDX_PRI_B][BIT_GRP_A_F])
        else $error("group a flag not set");
    pri_a_unused_a: assert property (s_q.regs[IDX_PRI_A][7] == 1'b0)
        else $error("unused bit of primary a set");
    edge_high_zero_a: assert property ((i_sfr.rd && i_sfr.addr == IDX_EDGE)
        |=> o_sfr_rvalid && o_sfr_rdata[7:4] == 4'h0)
        else $error("edge register upper bits not zero");

    suspend_seen_c: cover property ($rose(o_irq_suspend));
    group_path_c: cover property (grp_c_any ##1 s_q.regs[IDX_PRI_C][BIT_GRP_C_F] ##[1:3] o_irq_suspend);
    set_vs_clear_c: cover property (i_src.tb_a && i_sfr.wr && i_sfr.addr == IDX_PRI_C);
    ext_edge_c: cover property (pin_hit[1]);
endmodule
`default_nettype wire

/* irq_request_ctrl_tb.sv */
// self-checking testbench for the interrupt request control block
`timescale 1ns/100ps
`default_nettype none
module irq_request_ctrl_tb;
    import irq_ctrl_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_srst = 1'b1;
    sfr_req_s sfr = '0;
    irq_src_s src = '0;
    logic [1:0] pins = 2'h0;
    logic pin_chg = 1'b0;
    logic [7:0] o_sfr_rdata;
    logic o_sfr_rvalid;
    logic o_irq_suspend;
    int failures = 0;
    int checked = 0;
    // {register index, flag bit} for each internal source, struct order msb first
    localparam logic [5:0] SRC_MAP [16] = '{6'h0e, 6'h14, 6'h1d, 6'h1e, 6'h24, 6'h25, 6'h2c, 6'h2d,
        6'h2e, 6'h26, 6'h27, 6'h3c, 6'h3d, 6'h37, 6'h36, 6'h34};
    localparam logic [7:0] MASKS [8] = '{MASK_EDGE, MASK_PRI_A, MASK_PRI_B, MASK_PRI_C,
        MASK_GRP_A, MASK_GRP_B, MASK_GRP_C, MASK_GRP_D};

    irq_request_ctrl #(.EXT_PINS(2)) dut_u (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_sfr(sfr),
        .o_sfr_rdata(o_sfr_rdata),
        .o_sfr_rvalid(o_sfr_rvalid),
        .i_external_request_pins(pins),
        .i_pin_change_request_input(pin_chg),
        .i_src(src),
        .o_irq_suspend(o_irq_suspend)
    );

    // 100 MHz reference clock
    always #5 i_ref_clk = ~i_ref_clk;

    task automatic report_and_stop();
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // every stimulus change lands 1 ns after a rising edge, away from sampling
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_ref_clk); #1;
        sfr.wr = 1'b1; sfr.addr = a; sfr.wdata = d;
        @(posedge i_ref_clk); #1;
        sfr.wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_ref_clk); #1;
        sfr.rd = 1'b1; sfr.addr = a;
        @(posedge i_ref_clk); #1;
        sfr.rd = 1'b0;
        chk("read valid", 8'h01, {7'h0, o_sfr_rvalid});
        d = o_sfr_rdata;
    endtask

    task automatic apply_reset();
        @(posedge i_ref_clk); #1;
        i_srst = 1'b1;
        repeat (16) @(posedge i_ref_clk);
        #1 i_srst = 1'b0;
    endtask

    // writes before a reset must not survive it
    task automatic t_reset_values();
        logic [7:0] d;
        wr_reg(IDX_EDGE, 8'h0f);
        apply_reset();
        for (int a = 0; a < 8; a++) begin
            rd_reg(a[2:0], d);
            chk("reset value", RESET_VALUE, d);
        end
    endtask

    // all ones in, only implemented bits back; enabled members set group flags, so a second pass clears all
    task automatic t_masks();
        logic [7:0] d;
        for (int a = 0; a < 8; a++) begin
            wr_reg(a[2:0], 8'hff);
            rd_reg(a[2:0], d);
            chk("implemented bits", MASKS[a], d);
            wr_reg(a[2:0], 8'h00);
        end
        for (int a = 0; a < 8; a++) wr_reg(a[2:0], 8'h00);
    endtask

    // each internal pulse sets exactly its own flag, with every enable off
    task automatic t_sources();
        logic [7:0] d;
        for (int i = 0; i < 16; i++) begin
            @(posedge i_ref_clk); #1;
            src[15-i] = 1'b1;
            @(posedge i_ref_clk); #1;
            src = '0;
            rd_reg(SRC_MAP[i][5:3], d);
            chk("source flag", 8'h01 << SRC_MAP[i][2:0], d);
            chk("suspend idle", 8'h00, {7'h0, o_irq_suspend});
            wr_reg(SRC_MAP[i][5:3], 8'h00);
        end
    endtask

    // each edge code on each pin, one rising and one falling edge
    task automatic t_edges();
        logic [7:0] d;
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) begin
                wr_reg(IDX_EDGE, 8'(c) << (2 * p));
                @(posedge i_ref_clk); #1;
                pins[p] = 1'b1;
                repeat (8) @(posedge i_ref_clk);
                rd_reg(IDX_PRI_A, d);
                chk("rise flag", {7'h0, c[0]} << (BIT_EXT_A_F + p), d);
                wr_reg(IDX_PRI_A, 8'h00);
                @(posedge i_ref_clk); #1;
                pins[p] = 1'b0;
                repeat (8) @(posedge i_ref_clk);
                rd_reg(IDX_PRI_A, d);
                chk("fall flag", {7'h0, c[1]} << (BIT_EXT_A_F + p), d);
                wr_reg(IDX_PRI_A, 8'h00);
            end
        end
        wr_reg(IDX_EDGE, 8'h00);
    endtask

    // with flag and own enable set, suspend stays low until global enable is set, then clears with them
    task automatic t_direct_gate();
        wr_reg(IDX_PRI_A, 8'h08);
        @(posedge i_ref_clk); #1;
        src.cmp_a = 1'b1;
        @(posedge i_ref_clk); #1;
        src = '0;
        repeat (3) @(posedge i_ref_clk);
        #1;
        chk("suspend no global", 8'h00, {7'h0, o_irq_suspend});
        wr_reg(IDX_PRI_A, 8'h49);
        repeat (2) @(posedge i_ref_clk);
        #1;
        chk("suspend enabled", 8'h01, {7'h0, o_irq_suspend});
        wr_reg(IDX_PRI_A, 8'h00);
        repeat (2) @(posedge i_ref_clk);
        #1;
        chk("suspend cleared", 8'h00, {7'h0, o_irq_suspend});
    endtask

    // a hardware set in the same cycle as a software clear must win
    task automatic t_set_wins();
        logic [7:0] d;
        @(posedge i_ref_clk); #1;
        sfr.wr = 1'b1; sfr.addr = IDX_PRI_C; sfr.wdata = 8'h00;
        src.tb_a = 1'b1;
        @(posedge i_ref_clk); #1;
        sfr.wr = 1'b0;
        src = '0;
        rd_reg(IDX_PRI_C, d);
        chk("set beats clear", 8'h01 << BIT_TB_A_F, d);
        wr_reg(IDX_PRI_C, 8'h00);
    endtask

    // grouped source reaches suspend through the group flag and group enable
    task automatic t_group();
        logic [7:0] d;
        wr_reg(IDX_GRP_C, 8'h06);
        wr_reg(IDX_PRI_C, 8'h01);
        wr_reg(IDX_PRI_A, 8'h01);
        @(posedge i_ref_clk); #1;
        src.low_voltage_detector = 1'b1;
        pin_chg = 1'b1;
        @(posedge i_ref_clk); #1;
        src = '0;
        repeat (8) @(posedge i_ref_clk);
        #1;
        chk("group suspend", 8'h01, {7'h0, o_irq_suspend});
        rd_reg(IDX_GRP_C, d);
        chk("group members", 8'h66, d);
        rd_reg(IDX_PRI_C, d);
        chk("group flag", 8'h11, d);
        wr_reg(IDX_PRI_C, 8'h10);
        repeat (3) @(posedge i_ref_clk);
        #1;
        chk("group disabled", 8'h00, {7'h0, o_irq_suspend});
        pin_chg = 1'b0;
        for (int a = 0; a < 8; a++) wr_reg(3'(7 - a), 8'h00);
    endtask

    // hang guard, generous against the few hundred cycles the tests take
    initial begin
        #400000;
        failures++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge i_ref_clk);
        #1 i_srst = 1'b0;
        t_reset_values();
        t_masks();
        t_sources();
        t_edges();
        t_direct_gate();
        t_set_wins();
        t_group();
        report_and_stop();
    end
endmodule
`default_nettype wire
